// file: hdl/fep_cfg.svh
/*
 * constants for the erase and deep-sleep instruction handler: opcodes,
 * protection layout, reset values and timing counts.
 * assumes a 10 MHz system clock and an spi host on the pins.
 */
`ifndef FEP_CFG_SVH
`define FEP_CFG_SVH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define FEP_OP_HALF_BLOCK_ERASE 8'h52
`define FEP_OP_BLOCK_ERASE_64K 8'hD8
`define FEP_OP_CHIP_ERASE_A 8'hC7
`define FEP_OP_CHIP_ERASE_B 8'h60
`define FEP_OP_DEEP_SLEEP 8'hB9
`define FEP_OP_WAKE_AND_ID 8'hAB
`define FEP_OP_WRITE_ENABLE 8'h06
`define FEP_OP_STATUS_READ 8'h05

// ----------------------------------------------------------------
// frame layout, in serial clock rising edges
// ----------------------------------------------------------------
`define FEP_OPC_BITS 6'h08
`define FEP_ADDR_END_BITS 6'h20
`define FEP_ID_START_BITS 6'h20
`define FEP_BITCNT_MAX 6'h3F

// ----------------------------------------------------------------
// address map and protection
// ----------------------------------------------------------------
`define FEP_HALF_BLOCK_LSB 15
`define FEP_BLOCK_LSB 16
`define FEP_BLOCK_IDX_W 2
`define FEP_NUM_BLOCKS 3'h4

// ----------------------------------------------------------------
// reset values and identifier
// ----------------------------------------------------------------
`define FEP_DEVICE_ID_DEF 8'h5A
`define FEP_WEL_RST 1'b0

// ----------------------------------------------------------------
// timing: times in microseconds, counts in clock cycles
// ----------------------------------------------------------------
`define FEP_CLK_MHZ 10
`define FEP_HALF_BLOCK_ERASE_TIME_US 1000
`define FEP_BLOCK_ERASE_TIME_US 2000
`define FEP_CHIP_ERASE_TIME_US 8000
`define FEP_SLEEP_ENTRY_DELAY_US 3
`define FEP_WAKE_DELAY_US 3
`define FEP_WAKE_WITH_ID_DELAY_US 2
`define FEP_HALF_BLOCK_ERASE_CYC (`FEP_HALF_BLOCK_ERASE_TIME_US * `FEP_CLK_MHZ)
`define FEP_BLOCK_ERASE_CYC (`FEP_BLOCK_ERASE_TIME_US * `FEP_CLK_MHZ)
`define FEP_CHIP_ERASE_CYC (`FEP_CHIP_ERASE_TIME_US * `FEP_CLK_MHZ)
`define FEP_SLEEP_ENTRY_CYC (`FEP_SLEEP_ENTRY_DELAY_US * `FEP_CLK_MHZ)
`define FEP_WAKE_CYC (`FEP_WAKE_DELAY_US * `FEP_CLK_MHZ)
`define FEP_WAKE_WITH_ID_CYC (`FEP_WAKE_WITH_ID_DELAY_US * `FEP_CLK_MHZ)

`endif

// file: hdl/fep_pkg.sv
/*
 * types for the erase and deep-sleep instruction handler.
 * assumes nothing beyond a systemverilog compiler.
 */
package fep_pkg;

	// ----------------------------------------------------------------
	// device state, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_STANDBY = 5'h01,
		ST_ERASE = 5'h02,
		ST_DP_WAIT = 5'h04,
		ST_SLEEP = 5'h08,
		ST_WAKE_WAIT = 5'h10
	} fep_state_e;

	typedef enum logic [1:0] {
		EK_HALF = 2'h0,
		EK_BLOCK = 2'h1,
		EK_CHIP = 2'h2
	} fep_kind_e;

	// erase request handed to the array
	typedef struct packed {
		fep_kind_e kind;
		logic [23:0] base;
	} fep_erase_s;

endpackage

// file: hdl/fep_sync.sv
/*
 * two-flop synchroniser for a group of pin inputs.
 * assumes inputs asynchronous to clk_i; reset value is a parameter.
 */
module fep_sync #(
	parameter int WIDTH = 3,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// pins in, synchronised out
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta_q;

	initial begin
		if (WIDTH < 1) begin
			$error("fep_sync width must be at least one");
		end
	end

	// ----------------------------------------------------------------
	// two stages per bit
	// ----------------------------------------------------------------
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				meta_q[i] <= RST_VAL[i];
				q_o[i] <= RST_VAL[i];
			end else begin
				meta_q[i] <= d_i[i];
				q_o[i] <= meta_q[i];
			end
		end
	end

endmodule // fep_sync

// file: hdl/fep_top.sv
/*
 * erase, deep-sleep and wake/identifier instruction handler of a serial
 * nor flash. samples the spi pins on CLK_I, decodes the frame, times the
 * self-timed cycles and shifts out status or identifier on SO_O.
 * assumes the spi clock is much slower than CLK_I and that the block-protect
 * bits and otp mode come from logic on the same clock.
 */
// Function
// (RULE1) 52h plus address erases its 32KB block
// (RULE2) D8h plus address erases its 64KB block
// (RULE3) C7h or 60h erases the whole chip
// (RULE4) erase accepted only with write enable latch set
// (RULE5) host holds select low for whole sequence
// (RULE6) addressed erase needs rise after 32 bits
// (RULE7) chip erase, sleep need rise after 8 bits
// (RULE8) select rise starts cycle; busy flag tracks it
// (RULE9) write enable latch cleared during erase cycle
// (RULE10) protected block refuses half or full erase
// (RULE11) chip erase only with all protect bits zero
// (RULE12) B9h enters deep sleep after entry delay
// (RULE13) deep sleep ignores all but wake instruction
// (RULE14) deselect when idle gives ordinary standby
// (RULE15) reset always leaves deep sleep, starts standby
// (RULE16) sleep request during busy cycle is rejected
// (RULE17) ABh alone wakes after the wake delay
// (RULE18) ABh, three dummy bytes, identifier repeats out
// (RULE19) wake from sleep with id waits second delay
// (RULE20) wake when awake returns to standby immediately
// (RULE21) ABh ignored during erase, works otherwise; code also ignores it in ST_DP_WAIT and ST_WAKE_WAIT
// (RULE22) identifier served even without prior deep sleep
// (RULE23) otp mode disables chip, block, half erases
// (RULE24) delays are tick-count parameters from select rise
`include "fep_cfg.svh"

module fep_top import fep_pkg::*; #(
	parameter int unsigned HALF_ERASE_TICKS = `FEP_HALF_BLOCK_ERASE_CYC,
	parameter int unsigned BLOCK_ERASE_TICKS = `FEP_BLOCK_ERASE_CYC,
	parameter int unsigned CHIP_ERASE_TICKS = `FEP_CHIP_ERASE_CYC,
	parameter int unsigned SLEEP_TICKS = `FEP_SLEEP_ENTRY_CYC,
	parameter int unsigned WAKE_TICKS = `FEP_WAKE_CYC,
	parameter int unsigned WAKE_ID_TICKS = `FEP_WAKE_WITH_ID_CYC,
	parameter logic [7:0] DEVICE_ID = `FEP_DEVICE_ID_DEF // arbitrary value
) (
	// clock and reset
	input wire logic CLK_I,
	input wire logic RSTN_I,
	// spi pins
	input wire logic SCK_I,
	input wire logic CSN_I,
	input wire logic SERIAL_IN_I,
	output logic SO_O,
	output logic SO_OE_O,
	// configuration from the status logic
	input wire logic [3:0] BLOCK_PROTECT_BITS_I,
	input wire logic OTP_MODE_I,
	// status and array control
	output logic WRITE_IN_PROGRESS_O,
	output logic WRITE_ENABLE_LATCH_O,
	output logic DEEP_SLEEP_O,
	output logic ERASE_GO_O,
	output fep_erase_s ERASE_REQ_O
);

	initial begin
		if (HALF_ERASE_TICKS < 1 || BLOCK_ERASE_TICKS < 1 || CHIP_ERASE_TICKS < 1 ||
			SLEEP_TICKS < 1 || WAKE_TICKS < 1 || WAKE_ID_TICKS < 1) begin
			$error("fep_top delay counts must be at least one");
		end
	end

	// ----------------------------------------------------------------
	// pin sampling and edge detection
	// ----------------------------------------------------------------
	logic sck_s, csn_s, si_s, sck_d, csn_d;
	logic sck_rise, sck_fall, cs_rise;

	fep_sync #(.WIDTH(3), .RST_VAL(3'h2)) u_sync (
		.clk_i(CLK_I),
		.rstn_i(RSTN_I),
		.d_i({SCK_I, CSN_I, SERIAL_IN_I}),
		.q_o({sck_s, csn_s, si_s})
	);

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			sck_d <= 1'b0;
			csn_d <= 1'b1;
		end else begin
			sck_d <= sck_s;
			csn_d <= csn_s;
		end
	end

	assign sck_rise = sck_s && !sck_d && !csn_s;
	assign sck_fall = !sck_s && sck_d && !csn_s;
	assign cs_rise = csn_s && !csn_d;

	// ----------------------------------------------------------------
	// frame shifter
	// ----------------------------------------------------------------
	logic [5:0] bitcnt_q;
	logic [31:0] sr_q;
	logic [7:0] opc_q;
	logic [23:0] addr_q;
	logic [7:0] opc_now;

	assign opc_now = {sr_q[6:0], si_s};

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			bitcnt_q <= 6'h00;
			sr_q <= 32'h0000_0000;
			opc_q <= 8'h00;
			addr_q <= 24'h00_0000;
		end else if (csn_s) begin
			bitcnt_q <= 6'h00;
		end else if (sck_rise) begin
			sr_q <= {sr_q[30:0], si_s};
			if (bitcnt_q != `FEP_BITCNT_MAX) begin
				bitcnt_q <= bitcnt_q + 6'h01;
			end
			if (bitcnt_q == `FEP_OPC_BITS - 6'h01) begin
				opc_q <= opc_now;
			end
			if (bitcnt_q == `FEP_ADDR_END_BITS - 6'h01) begin
				addr_q <= {sr_q[22:0], si_s};
			end
		end
	end

	// ----------------------------------------------------------------
	// frame acceptance, judged at the end of the opcode
	// ----------------------------------------------------------------
	fep_state_e state_q;
	logic frame_ok_q;
	logic busy_ok;

	always_comb begin
		busy_ok = 1'b0;
		case (state_q)
			ST_STANDBY: busy_ok = 1'b1;
			ST_SLEEP: busy_ok = (opc_now == `FEP_OP_WAKE_AND_ID); // [RULE13]
			ST_ERASE: busy_ok = (opc_now == `FEP_OP_STATUS_READ); // [RULE16] [RULE21]
			default: busy_ok = 1'b0;
		endcase
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			frame_ok_q <= 1'b0;
		end else if (csn_s) begin
			frame_ok_q <= 1'b0;
		end else if (sck_rise && bitcnt_q == `FEP_OPC_BITS - 6'h01) begin
			frame_ok_q <= busy_ok;
		end
	end

	// ----------------------------------------------------------------
	// decode at select rise
	// ----------------------------------------------------------------
	logic is_half, is_block, is_chip, is_sleep, is_wake, is_write_enable_cmd;
	logic len_opc, len_addr, blk_prot, erase_ok, start_erase;
	logic [2:0] nprot;

	assign is_half = opc_q == `FEP_OP_HALF_BLOCK_ERASE;
	assign is_block = opc_q == `FEP_OP_BLOCK_ERASE_64K;
	assign is_chip = opc_q == `FEP_OP_CHIP_ERASE_A || opc_q == `FEP_OP_CHIP_ERASE_B;
	assign is_sleep = opc_q == `FEP_OP_DEEP_SLEEP;
	assign is_wake = opc_q == `FEP_OP_WAKE_AND_ID;
	assign is_write_enable_cmd = opc_q == `FEP_OP_WRITE_ENABLE;
	assign len_opc = bitcnt_q == `FEP_OPC_BITS; // [RULE7]
	assign len_addr = bitcnt_q == `FEP_ADDR_END_BITS; // [RULE6]

	// protect value n guards the top n 64KB blocks, four or more guards all
	assign nprot = (BLOCK_PROTECT_BITS_I >= 4'(`FEP_NUM_BLOCKS)) ? `FEP_NUM_BLOCKS : BLOCK_PROTECT_BITS_I[2:0];
	assign blk_prot = ({1'b0, addr_q[`FEP_BLOCK_LSB +: `FEP_BLOCK_IDX_W]} >= (`FEP_NUM_BLOCKS - nprot)); // [RULE10]

	assign erase_ok = (((is_half || is_block) && len_addr && !blk_prot) || // [RULE1] [RULE2] [RULE10]
		(is_chip && len_opc && BLOCK_PROTECT_BITS_I == 4'h0)) && // [RULE3] [RULE11]
		WRITE_ENABLE_LATCH_O && !OTP_MODE_I; // [RULE4] [RULE23]
	assign start_erase = cs_rise && frame_ok_q && state_q == ST_STANDBY && erase_ok; // [RULE8]

	// ----------------------------------------------------------------
	// device state and delay counter
	// ----------------------------------------------------------------
	logic [31:0] cnt_q;

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			state_q <= ST_STANDBY; // [RULE15]
			cnt_q <= 32'h0000_0000;
		end else begin
			case (state_q)
				ST_STANDBY: begin
					if (start_erase) begin
						state_q <= ST_ERASE;
						cnt_q <= is_chip ? CHIP_ERASE_TICKS - 1 : // [RULE24]
							is_block ? BLOCK_ERASE_TICKS - 1 : HALF_ERASE_TICKS - 1;
					end else if (cs_rise && frame_ok_q && is_sleep && len_opc) begin
						state_q <= ST_DP_WAIT; // [RULE12]
						cnt_q <= SLEEP_TICKS - 1;
					end
					// a wake frame here leaves standby as it is [RULE20] [RULE22] [RULE14]
				end
				ST_ERASE: begin
					if (cnt_q == 32'h0000_0000) begin
						state_q <= ST_STANDBY;
					end else begin
						cnt_q <= cnt_q - 32'h0000_0001;
					end
				end
				ST_DP_WAIT: begin
					if (cnt_q == 32'h0000_0000) begin
						state_q <= ST_SLEEP;
					end else begin
						cnt_q <= cnt_q - 32'h0000_0001;
					end
				end
				ST_SLEEP: begin
					if (cs_rise && frame_ok_q && is_wake) begin
						state_q <= ST_WAKE_WAIT;
						cnt_q <= len_opc ? WAKE_TICKS - 1 : WAKE_ID_TICKS - 1; // [RULE17] [RULE19]
					end
				end
				ST_WAKE_WAIT: begin
					if (cnt_q == 32'h0000_0000) begin
						state_q <= ST_STANDBY;
					end else begin
						cnt_q <= cnt_q - 32'h0000_0001;
					end
				end
				default: begin
					state_q <= ST_STANDBY;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// status outputs and erase request
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			WRITE_IN_PROGRESS_O <= 1'b0;
			DEEP_SLEEP_O <= 1'b0;
		end else begin
			WRITE_IN_PROGRESS_O <= start_erase || (state_q == ST_ERASE && cnt_q != 32'h0000_0000); // [RULE8]
			DEEP_SLEEP_O <= (state_q == ST_DP_WAIT && cnt_q == 32'h0000_0000) || state_q == ST_SLEEP ||
				(state_q == ST_WAKE_WAIT && cnt_q != 32'h0000_0000); // [RULE17] [RULE19]
		end
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			WRITE_ENABLE_LATCH_O <= `FEP_WEL_RST;
		end else if (start_erase) begin
			WRITE_ENABLE_LATCH_O <= 1'b0; // [RULE9]
		end else if (cs_rise && frame_ok_q && state_q == ST_STANDBY && is_write_enable_cmd && len_opc) begin
			WRITE_ENABLE_LATCH_O <= 1'b1;
		end
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ERASE_GO_O <= 1'b0;
			ERASE_REQ_O <= '{kind: EK_HALF, base: 24'h00_0000};
		end else begin
			ERASE_GO_O <= start_erase;
			if (start_erase) begin
				if (is_chip) begin
					ERASE_REQ_O <= '{kind: EK_CHIP, base: 24'h00_0000}; // [RULE3]
				end else if (is_block) begin
					ERASE_REQ_O <= '{kind: EK_BLOCK, base: {addr_q[23:`FEP_BLOCK_LSB], 16'h0000}}; // [RULE2]
				end else begin
					ERASE_REQ_O <= '{kind: EK_HALF, base: {addr_q[23:`FEP_HALF_BLOCK_LSB], 15'h0000}}; // [RULE1]
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// serial output: identifier or status, rotated on falling edges
	// ----------------------------------------------------------------
	logic [7:0] out_sr_q;
	logic out_on_q;

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			out_sr_q <= 8'h00;
			out_on_q <= 1'b0;
			SO_O <= 1'b0;
			SO_OE_O <= 1'b0;
		end else if (csn_s) begin
			out_on_q <= 1'b0;
			SO_OE_O <= 1'b0;
		end else if (sck_rise && frame_ok_q && is_wake && bitcnt_q == `FEP_ID_START_BITS - 6'h01) begin
			out_sr_q <= DEVICE_ID; // [RULE18] [RULE22]
			out_on_q <= 1'b1;
		end else if (sck_rise && frame_ok_q && opc_q == `FEP_OP_STATUS_READ && bitcnt_q == `FEP_OPC_BITS) begin
			out_sr_q <= {6'h00, WRITE_ENABLE_LATCH_O, WRITE_IN_PROGRESS_O}; // [RULE8]
			out_on_q <= 1'b1;
		end else if (sck_fall && out_on_q) begin
			SO_O <= out_sr_q[7]; // [RULE18]
			SO_OE_O <= 1'b1;
			out_sr_q <= {out_sr_q[6:0], out_sr_q[7]};
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);

	chk_erase_needs_wel: assert property ($rose(WRITE_IN_PROGRESS_O) |-> $past(WRITE_ENABLE_LATCH_O)) // [RULE4]
		else $error("erase started without write enable latch");
	chk_wel_cleared: assert property ($rose(WRITE_IN_PROGRESS_O) |-> !WRITE_ENABLE_LATCH_O) // [RULE9]
		else $error("write enable latch not cleared at erase start");
	chk_erase_at_rise: assert property ($rose(WRITE_IN_PROGRESS_O) |-> $past(cs_rise) && ERASE_GO_O) // [RULE8]
		else $error("erase began without select rise");
	chk_chip_unprotected: assert property ($rose(WRITE_IN_PROGRESS_O) && ERASE_REQ_O.kind == EK_CHIP
		|-> $past(BLOCK_PROTECT_BITS_I) == 4'h0) // [RULE11]
		else $error("chip erase with protection set");
	chk_otp_blocks: assert property ($rose(WRITE_IN_PROGRESS_O) |-> !$past(OTP_MODE_I)) // [RULE23]
		else $error("erase accepted in otp mode");
	chk_addr_len: assert property ($rose(WRITE_IN_PROGRESS_O) && ERASE_REQ_O.kind != EK_CHIP
		|-> $past(bitcnt_q) == `FEP_ADDR_END_BITS) // [RULE6]
		else $error("addressed erase with wrong frame length");
	chk_sleep_entry: assert property (cs_rise && frame_ok_q && state_q == ST_STANDBY && is_sleep && len_opc
		|-> !DEEP_SLEEP_O ##1 state_q == ST_DP_WAIT) // [RULE12]
		else $error("sleep request not taken");
	chk_sleep_quiet: assert property (state_q == ST_SLEEP |=> !WRITE_IN_PROGRESS_O && !$rose(WRITE_ENABLE_LATCH_O)) // [RULE13]
		else $error("instruction acted on in deep sleep");
	chk_busy_no_sleep: assert property (WRITE_IN_PROGRESS_O |-> !DEEP_SLEEP_O && state_q != ST_DP_WAIT) // [RULE16]
		else $error("sleep entered during erase");
	chk_wake_flag: assert property (state_q == ST_WAKE_WAIT |-> DEEP_SLEEP_O) else $error("wake flag low"); // [RULE17]
	cov_block_erase: cover property ($rose(WRITE_IN_PROGRESS_O) && ERASE_REQ_O.kind == EK_BLOCK);
	cov_chip_erase: cover property ($rose(WRITE_IN_PROGRESS_O) && ERASE_REQ_O.kind == EK_CHIP);
	cov_sleep_wake: cover property ($fell(DEEP_SLEEP_O));
	cov_id_out: cover property ($rose(SO_OE_O) && is_wake);

endmodule // fep_top

// file: dv/fep_spi_host.sv
/*
 spi host model that sends instruction frames and reads the answer on SO.
 assumes the bench calls xfer just after a system clock edge; sck idles low.
*/
module fep_spi_host (
	// spi pins towards the device
	output logic sck_o,
	output logic csn_o,
	output logic si_o,
	// answer from the device
	input wire logic so_i,
	input wire logic so_oe_i
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HALF = 400;
	logic oe_seen;

	// ----------------------------------------------------------------
	// frame driver
	// ----------------------------------------------------------------
	initial begin
		sck_o = 1'h0;
		csn_o = 1'h1;
		si_o = 1'h0;
		oe_seen = 1'h0;
	end

	always @(posedge so_oe_i) oe_seen = 1'h1;

	// sends nb bits of tx msb first, then clocks nr bits in from so
	task automatic xfer(input logic [31:0] tx, input int nb, input int nr, output logic [15:0] rx);
		rx = 16'h0000;
		oe_seen = 1'h0;
		csn_o = 1'h0;
		#HALF;
		for (int i = 0; i < nb; i++) begin
			si_o = tx[31-i];
			#HALF;
			sck_o = 1'h1;
			#HALF;
			sck_o = 1'h0;
		end
		for (int i = 0; i < nr; i++) begin
			si_o = ~si_o;
			#HALF;
			sck_o = 1'h1;
			#(HALF / 2);
			rx = {rx[14:0], so_oe_i ? so_i : ~so_i}; // released line shows the inverse
			#(HALF / 2);
			sck_o = 1'h0;
		end
		#HALF;
		csn_o = 1'h1;
		si_o = ~si_o;
	endtask
endmodule // fep_spi_host

// file: dv/fep_top_tb_top.sv
/*
 self-checking bench for the erase and deep-sleep instruction handler.
 assumes fep_spi_host as the far side and shortened tick parameters.
*/
module fep_top_tb_top import fep_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HT = 200;
	localparam int BT = 300;
	localparam int CT = 600;
	localparam int ST = 6;
	localparam int WT = 5;
	localparam int WIT = 12;
	localparam int LIMIT = 30000;
	localparam logic [7:0] ID = 8'hA6; // arbitrary value
	localparam fep_erase_s NONE = '{EK_HALF, 24'h000000};
	logic clk, rstn, sck, csn, si, so, so_oe, otp, write_in_progress, write_enable_latch, dsl, go;
	logic [3:0] bp;
	logic [15:0] rx;
	fep_erase_s req;
	int err_total, total_checks, cyc;

	// ----------------------------------------------------------------
	// design and far side
	// ----------------------------------------------------------------
	fep_top #(.HALF_ERASE_TICKS(HT), .BLOCK_ERASE_TICKS(BT), .CHIP_ERASE_TICKS(CT), .SLEEP_TICKS(ST),
		.WAKE_TICKS(WT), .WAKE_ID_TICKS(WIT), .DEVICE_ID(ID)) i_dut (
		.CLK_I(clk), .RSTN_I(rstn), .SCK_I(sck), .CSN_I(csn), .SERIAL_IN_I(si), .SO_O(so),
		.SO_OE_O(so_oe), .BLOCK_PROTECT_BITS_I(bp), .OTP_MODE_I(otp), .WRITE_IN_PROGRESS_O(write_in_progress),
		.WRITE_ENABLE_LATCH_O(write_enable_latch), .DEEP_SLEEP_O(dsl), .ERASE_GO_O(go), .ERASE_REQ_O(req));
	fep_spi_host i_host (.sck_o(sck), .csn_o(csn), .si_o(si), .so_i(so), .so_oe_i(so_oe));

	always #50 clk = ~clk;

	always @(posedge clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			err_total++;
			$display("FAIL timeout exp %0d got %0d", LIMIT - 1, cyc);
			wrap_up();
		end
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk_v(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %s exp %h got %h", nm, exp, got);
		end
	endtask

	task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
		total_checks++;
		if (got < lo || got > hi) begin
			err_total++;
			$display("FAIL %s exp %0d..%0d got %0d", nm, lo, hi, got);
		end
	endtask

	task automatic done(input string nm);
		$display("test %s done", nm);
	endtask

	task automatic fr(input logic [31:0] tx, input int nb, input int nr);
		i_host.xfer(tx, nb, nr, rx);
	endtask

	task automatic write_enable_cmd();
		fr(32'h06000000, 8, 0);
		tick(6);
		chk_v("wel_set", 1, write_enable_latch);
	endtask

	// t above zero waits for the end of the cycle and counts it
	task automatic erase(input logic [31:0] tx, input int nb, input logic exp, input fep_erase_s er, input int t);
		int n;
		n = 0;
		write_enable_cmd();
		fr(tx, nb, 0);
		while (go !== 1'h1 && n < 12) begin
			tick(1);
			n++;
		end
		chk_v("erase_go", exp, go);
		if (exp) begin
			chk_v("erase_kind", er.kind, req.kind);
			if (er.kind != EK_CHIP) chk_v("erase_base", er.base, req.base);
			chk_v("wel_clear", 0, write_enable_latch);
			n = 0;
			while (write_in_progress === 1'h1 && n < 1000 && t > 0) begin
				tick(1);
				n++;
			end
			if (t > 0) chk_rng("erase_ticks", t, t, n);
		end else begin
			chk_v("wip_idle", 0, write_in_progress);
		end
	endtask

	task automatic wait_dsl(input logic lvl, input int t, input string nm);
		int n;
		n = 0;
		while (dsl !== lvl && n < 100) begin
			tick(1);
			n++;
		end
		chk_rng(nm, t + 3, t + 7, n);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		clk = 1'h0;
		rstn = 1'h0;
		bp = 4'h0;
		otp = 1'h0;
		err_total = 0;
		total_checks = 0;
		cyc = 0;
		tick(12);
		chk_v("reset_outs", 0, {so, so_oe, write_in_progress, write_enable_latch, dsl, go, req});
		rstn = 1'h1;
		tick(3);
		done("reset");
		fr(32'hD8020000, 32, 0);
		tick(12);
		chk_v("no_wel_wip", 0, write_in_progress);
		chk_v("standby", 0, dsl);
		done("no_write_enable");
		erase(32'hD8023456, 32, 1, '{EK_BLOCK, 24'h020000}, BT);
		erase(32'h52019ABC, 32, 1, '{EK_HALF, 24'h018000}, HT);
		erase(32'hC7000000, 8, 1, '{EK_CHIP, 24'h0}, CT);
		erase(32'h60000000, 8, 1, '{EK_CHIP, 24'h0}, CT);
		done("erase_kinds");
		erase(32'hD8023456, 31, 0, NONE, 0);
		erase(32'h52023456, 8, 0, NONE, 0);
		erase(32'hC7000000, 9, 0, NONE, 0);
		fr(32'hB9000000, 9, 0);
		tick(12);
		chk_v("sleep_len", 0, dsl);
		done("frame_length");
		bp = 4'h1;
		erase(32'hD8030000, 32, 0, NONE, 0);
		erase(32'h5203F000, 32, 0, NONE, 0);
		erase(32'hD8020000, 32, 1, '{EK_BLOCK, 24'h020000}, BT);
		erase(32'hC7000000, 8, 0, NONE, 0);
		bp = 4'h0;
		otp = 1'h1;
		erase(32'hD8000000, 32, 0, NONE, 0);
		erase(32'h52000000, 32, 0, NONE, 0);
		erase(32'hC7000000, 8, 0, NONE, 0);
		otp = 1'h0;
		done("protection");
		erase(32'hC7000000, 8, 1, '{EK_CHIP, 24'h0}, 0);
		fr(32'hB9000000, 8, 0);
		tick(20);
		chk_v("busy_sleep", 0, dsl);
		fr(32'hAB000000, 32, 8);
		chk_v("busy_id_oe", 0, i_host.oe_seen);
		chk_v("busy_wip", 1, write_in_progress);
		tick(4);
		fr(32'h05000000, 8, 9);
		chk_v("busy_status", 8'h01, rx[7:0]);
		while (write_in_progress === 1'h1) tick(1);
		done("busy");
		fr(32'hB9000000, 8, 0);
		wait_dsl(1, ST, "sleep_entry");
		fr(32'h06000000, 8, 0);
		tick(8);
		chk_v("sleep_wel", 0, write_enable_latch);
		fr(32'hAB000000, 8, 0);
		wait_dsl(0, WT, "wake");
		done("sleep_wake");
		fr(32'hAB000000, 32, 16);
		chk_v("id_awake", {ID, ID}, rx);
		chk_v("id_oe", 1, i_host.oe_seen);
		tick(4);
		chk_v("id_standby", 0, dsl);
		write_enable_cmd();
		fr(32'hB9000000, 8, 0);
		wait_dsl(1, ST, "sleep_again");
		fr(32'hAB000000, 32, 16);
		chk_v("id_sleep", {ID, ID}, rx);
		wait_dsl(0, WIT, "wake_id");
		done("identifier");
		fr(32'hB9000000, 8, 0);
		wait_dsl(1, ST, "sleep_pre_reset");
		rstn = 1'h0;
		tick(2);
		chk_v("reset_sleep", 0, dsl);
		chk_v("reset_wel", 0, write_enable_latch);
		rstn = 1'h1;
		tick(3);
		done("reset_in_sleep");
		wrap_up();
	end
endmodule // fep_top_tb_top
